// ===== rtl/zsf_zero_subband_fill.sv
/*
  zsf_zero_subband_fill: per-frame problem detection and correlation
  fill of zero sub-bands for the enhancement layers.
  assumes: frame_in stands steady in the frame_start cycle; one clock,
  synchronous reset, ce freezes everything.
*/
// Implementation choices: the register offsets and the plain strobed port.
// Contract
// - counter per frame, values zero to 20
// - flag is one when counter above zero
// - detect only with both layers sent
// - envelope error ratio, class_a uses index j/2
// - first sub-flag when max ratio exceeds four
// - second sub-flag from peak versus average energy
// - clamp counter to 0..20 each frame
// - send flag bit, spend one unused bit
// - flag one restrains fill to scaled envelope
// - flag zero fills from base or correlation
// - flag changes only with unused bits present
// - only first layer forces flag zero, unsent
// - fill needs both layers, flag zero, four bits
// - base spectrum 24 coefs, three nonzero needed
// - targets are first two zero sub-bands
// - first search lags 0 to 14
// - positive max sends lag, scaled base fill
// - correction from base energy at lag
// - negative first max sends fifteen
// - second search, first target if no lag1
// - second search lag or fifteen likewise
// - first layer quantizer budget is 36 bits
// - at least one zero sub-band remains
`timescale 1ns/1ns
module zsf_zero_subband_fill (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic frame_start,
  input wire zsf_pkg::zsf_frame_in_s frame_in,
  output logic frame_busy,
  output logic frame_done,
  output zsf_pkg::zsf_frame_out_s frame_out
);
  zsf_pkg::zsf_state_e state_reg;
  logic [5:0][3:0] table_reg;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic f0_reg;
  logic f0_next;
  logic accept;
  logic s1_next;
  logic [1:0] s2_next;
  logic [3:0] zcount;
  logic [3:0] nzcount;
  logic [2:0] tidx;
  logic signed [5:0] csum;
  logic [5:0] u1_eff;
  logic [5:0] u1_left;
  logic [5:0] u2_eff;
  logic flag_send;
  logic fill_ok;
  logic run1;
  logic run2;
  logic run2_reg;
  logic [23:0][7:0] base_reg;
  logic [7:0][7:0] tgt1_reg;
  logic [7:0][7:0] tgt2_reg;
  logic [3:0] lag_reg;
  logic signed [18:0] best_corr;
  logic [3:0] best_lag;
  logic [17:0] best_en;
  logic signed [15:0] prod [zsf_pkg::NCO];
  logic [15:0] sq [zsf_pkg::NCO];
  logic signed [18:0] corr;
  logic [17:0] energy;
  logic better;
  logic signed [18:0] win_corr;
  logic [3:0] win_lag;
  logic [17:0] win_en;
  logic [3:0] win_code;
  zsf_pkg::zsf_frame_out_s res_reg;

  // index of the n-th set bit of m, lowest first
  function automatic logic [2:0] nth_sb(input logic [7:0] m,
                                        input logic [1:0] n);
    logic [1:0] k;
    logic [2:0] r;
    logic found;
    k = 2'h0;
    r = 3'h0;
    found = 1'b0;
    for (int j = 0; j < zsf_pkg::NSB; j++)
    begin
      if (m[j] && !found)
      begin
        if (k == n)
        begin
          r = 3'(j);
          found = 1'b1;
        end
        k = k + 2'h1;
      end
    end
    return r;
  endfunction

  assign accept = ce && frame_start && (state_reg == zsf_pkg::S_IDLE);
  assign frame_busy = state_reg != zsf_pkg::S_IDLE;
  assign frame_out = res_reg;

  // sub-flags from envelope error and energy peaks of zero sub-bands
  always_comb
  begin
    zcount = 4'($countones(frame_in.zero_mask));
    nzcount = zsf_pkg::SB_COUNT - zcount;
    s1_next = 1'b0;
    s2_next = 2'h0;
    for (int j = 0; j < zsf_pkg::NSB; j++)
    begin
      if (frame_in.zero_mask[j])
      begin
        // class_a frames share one envelope per sub-band pair
        if (frame_in.frame_class_a)
        begin
          if (15'(frame_in.env_q[j / 2]) >
              15'(frame_in.env_o[j / 2]) * zsf_pkg::ENV_RATIO_MUL)
            s1_next = 1'b1;
        end
        else if (15'(frame_in.env_q[j]) >
                 15'(frame_in.env_o[j]) * zsf_pkg::ENV_RATIO_MUL)
          s1_next = 1'b1;
        // stop updating once the high value is reached
        if (s2_next != zsf_pkg::S2_HIGH)
        begin
          if (18'(frame_in.e_peak[j]) * zsf_pkg::PK_HI_L >
              18'(frame_in.e_sum[j]) * zsf_pkg::PK_HI_R)
            s2_next = zsf_pkg::S2_HIGH;
          else if (zcount >= zsf_pkg::ZC_PEAK_MIN &&
                   18'(frame_in.e_peak[j]) * zsf_pkg::PK_LO_L >
                   18'(frame_in.e_sum[j]))
            s2_next = zsf_pkg::S2_LOW;
        end
      end
    end
  end

  // counter step and clamp; only the sparse mode graph is modelled
  always_comb
  begin
    tidx = 3'(s2_next) + (s1_next ? zsf_pkg::TBL_S1_OFS : 3'h0);
    csum = $signed({1'b0, cnt_reg}) + 6'($signed(table_reg[tidx]));
    if (csum < 0)
      cnt_next = 5'h00;
    else if (csum > $signed({1'b0, zsf_pkg::CNT_MAX}))
      cnt_next = zsf_pkg::CNT_MAX;
    else
      cnt_next = 5'(csum);
    if (!frame_in.both_layers || frame_in.shb_mode != zsf_pkg::MODE_SPARSE)
      cnt_next = cnt_reg;
  end

  // flag decision, bit spending and fill gating
  always_comb
  begin
    // budgets above the layer size are treated as the full size
    u1_eff = (frame_in.unused1 > zsf_pkg::L1_AVQ_BITS) ?
             zsf_pkg::L1_AVQ_BITS : frame_in.unused1;
    u2_eff = (frame_in.unused2 > zsf_pkg::L2_AVQ_BITS) ?
             zsf_pkg::L2_AVQ_BITS : frame_in.unused2;
    flag_send = frame_in.both_layers &&
                u1_eff >= zsf_pkg::FLAG_BITS;
    if (!frame_in.both_layers)
      f0_next = 1'b0;
    else if (flag_send)
      f0_next = cnt_next != 5'h00;
    else
      f0_next = f0_reg;
    u1_left = flag_send ? u1_eff - zsf_pkg::FLAG_BITS : u1_eff;
    fill_ok = frame_in.both_layers && !f0_next && zcount != 4'h0 &&
              nzcount >= zsf_pkg::NZ_MIN &&
              (u1_left >= zsf_pkg::LAG_BITS ||
               u2_eff >= zsf_pkg::LAG_BITS);
    run1 = fill_ok && u1_left >= zsf_pkg::LAG_BITS;
    // a second target exists only with two zero sub-bands
    run2 = fill_ok && u2_eff >= zsf_pkg::LAG_BITS &&
           (!run1 || zcount >= 4'h2);
  end

  // detection counter and flag keep their value across frames
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 5'h00;
      f0_reg <= 1'b0;
    end
    else if (accept)
    begin
      cnt_reg <= cnt_next;
      f0_reg <= f0_next;
    end
  end

  // snapshot base spectrum and targets at frame start
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      base_reg <= '0;
      tgt1_reg <= '0;
      tgt2_reg <= '0;
      run2_reg <= 1'b0;
    end
    else if (accept)
    begin
      run2_reg <= run2;
      for (int s = 0; s < zsf_pkg::NBASE_SB; s++)
        for (int i = 0; i < zsf_pkg::NCO; i++)
          base_reg[8 * s + i] <= frame_in.dec_spec[
            {nth_sb(~frame_in.zero_mask, 2'(s)), 3'(i)}];
      for (int i = 0; i < zsf_pkg::NCO; i++)
      begin
        tgt1_reg[i] <= frame_in.orig_spec[
          {nth_sb(frame_in.zero_mask, 2'h0), 3'(i)}];
        tgt2_reg[i] <= frame_in.orig_spec[
          {nth_sb(frame_in.zero_mask, run1 ? 2'h1 : 2'h0), 3'(i)}];
      end
    end
  end

  // one lag per cycle: dot product and base energy over eight terms
  for (genvar gi = 0; gi < zsf_pkg::NCO; gi++)
  begin : g_term
    logic [7:0] bcoef;
    assign bcoef = base_reg[5'(lag_reg) + 5'(gi)];
    assign prod[gi] = $signed(bcoef) * $signed(
      (state_reg == zsf_pkg::S_SRCH2) ? tgt2_reg[gi] : tgt1_reg[gi]);
    assign sq[gi] = 16'($signed(bcoef) * $signed(bcoef));
  end

  always_comb
  begin
    corr = 19'sh0_0000;
    energy = 18'h0_0000;
    for (int i = 0; i < zsf_pkg::NCO; i++)
    begin
      corr = corr + 19'(prod[i]);
      energy = energy + 18'(sq[i]);
    end
    // first lag of a tie wins
    better = (lag_reg == 4'h0) || (corr > best_corr);
    win_corr = better ? corr : best_corr;
    win_lag = better ? lag_reg : best_lag;
    win_en = better ? energy : best_en;
    win_code = (win_corr > 0) ? win_lag : zsf_pkg::ESC_CODE;
  end

  // frame sequencer, lag search and result assembly
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_reg <= zsf_pkg::S_IDLE;
      lag_reg <= 4'h0;
      best_corr <= 19'sh0_0000;
      best_lag <= 4'h0;
      best_en <= 18'h0_0000;
      res_reg <= '0;
      frame_done <= 1'b0;
    end
    else if (ce)
    begin
      frame_done <= 1'b0;
      unique case (state_reg)
        zsf_pkg::S_IDLE:
        begin
          if (frame_start)
          begin
            lag_reg <= 4'h0;
            res_reg <= '0;
            res_reg.flag_sent <= flag_send;
            res_reg.flag_val <= flag_send && f0_next;
            res_reg.restrain_fill <= flag_send && f0_next;
            res_reg.fill1_sb <= nth_sb(frame_in.zero_mask, 2'h0);
            res_reg.fill2_sb <= nth_sb(frame_in.zero_mask,
                                       run1 ? 2'h1 : 2'h0);
            res_reg.unused1_left <= u1_left;
            res_reg.unused2_left <= u2_eff;
            if (run1)
              state_reg <= zsf_pkg::S_SRCH1;
            else if (run2)
              state_reg <= zsf_pkg::S_SRCH2;
            else
              state_reg <= zsf_pkg::S_DONE;
          end
        end
        zsf_pkg::S_SRCH1, zsf_pkg::S_SRCH2:
        begin
          best_corr <= win_corr;
          best_lag <= win_lag;
          best_en <= win_en;
          lag_reg <= lag_reg + 4'h1;
          if (lag_reg == zsf_pkg::LAG_LAST)
          begin
            lag_reg <= 4'h0;
            if (state_reg == zsf_pkg::S_SRCH1)
            begin
              res_reg.lag1_sent <= 1'b1;
              res_reg.lag1 <= win_code;
              res_reg.corr1 <= win_corr;
              res_reg.energy1 <= win_en;
              res_reg.unused1_left <= res_reg.unused1_left -
                                      zsf_pkg::LAG_BITS;
              state_reg <= run2_reg ? zsf_pkg::S_SRCH2 : zsf_pkg::S_DONE;
            end
            else
            begin
              res_reg.lag2_sent <= 1'b1;
              res_reg.lag2 <= win_code;
              res_reg.corr2 <= win_corr;
              res_reg.energy2 <= win_en;
              res_reg.unused2_left <= res_reg.unused2_left -
                                      zsf_pkg::LAG_BITS;
              state_reg <= zsf_pkg::S_DONE;
            end
          end
        end
        zsf_pkg::S_DONE:
        begin
          frame_done <= 1'b1;
          state_reg <= zsf_pkg::S_IDLE;
        end
      endcase
    end
  end

  // register port: table write, status and lag readback
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      table_reg <= zsf_pkg::TABLE_RST;
      reg_rdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_wr && reg_addr == zsf_pkg::REG_TABLE)
        table_reg <= reg_wdata[23:0];
      if (reg_rd)
      begin
        unique case (reg_addr)
          zsf_pkg::REG_TABLE: reg_rdata <= {8'h00, table_reg};
          zsf_pkg::REG_STATUS:
            reg_rdata <= {25'h000_0000, frame_busy, f0_reg, cnt_reg};
          zsf_pkg::REG_LAGS:
            reg_rdata <= {24'h00_0000, res_reg.lag2, res_reg.lag1};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_cnt_range: assert property (@(posedge mclk) disable iff (sys_rst)
    cnt_reg <= zsf_pkg::CNT_MAX) else $error("counter out of range");
  a_flag_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    accept && flag_send |=> f0_reg == (cnt_reg != 5'h00))
    else $error("flag does not follow counter");
  a_flag_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    accept && frame_in.both_layers && !flag_send |=> $stable(f0_reg))
    else $error("flag changed without unused bits");
  a_only_first: assert property (@(posedge mclk) disable iff (sys_rst)
    accept && !frame_in.both_layers |=> !f0_reg && !res_reg.flag_sent
    && $stable(cnt_reg)) else $error("single layer frame touched flag");
  a_bit_spend: assert property (@(posedge mclk) disable iff (sys_rst)
    accept && flag_send |=> res_reg.unused1_left == $past(u1_eff) - 6'h01)
    else $error("flag bit not spent");
  a_search_len: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && state_reg == zsf_pkg::S_SRCH1 && lag_reg == zsf_pkg::LAG_LAST
    |=> state_reg != zsf_pkg::S_SRCH1) else $error("search overran");
  a_esc_code: assert property (@(posedge mclk) disable iff (sys_rst)
    frame_done && res_reg.lag1_sent |->
    (res_reg.lag1 == zsf_pkg::ESC_CODE) == (res_reg.corr1 <= 0))
    else $error("escape code mismatch");
  a_fill_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    frame_done && (res_reg.lag1_sent || res_reg.lag2_sent) |->
    !res_reg.flag_val && !res_reg.restrain_fill)
    else $error("fill while flag set");
  a_done_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && frame_done |=> !frame_done)
    else $error("done longer than one cycle");
endmodule

// ===== rtl/zsf_pkg.sv
/*
  zsf_pkg: constants, types and register map of the zero sub-band
  detect and fill block.
  assumes: spectra arrive already ordered by perceptual importance.
*/
package zsf_pkg;
  localparam int NSB = 8;
  localparam int NCO = 8;
  localparam int NBASE = 24;
  localparam int NBASE_SB = 3;

  // register map, byte offsets of 32-bit words
  localparam logic [3:0] REG_TABLE = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LAGS = 4'h8;
  // counter deltas, nibble per s1*3+s2 index, two's complement
  localparam logic [23:0] TABLE_RST = 24'h43_321f;
  localparam logic [2:0] TBL_S1_OFS = 3'h3;

  localparam logic [4:0] CNT_MAX = 5'h14;
  localparam logic [1:0] MODE_SPARSE = 2'h0;
  localparam logic [5:0] L1_AVQ_BITS = 6'h24;
  localparam logic [5:0] L2_AVQ_BITS = 6'h28;
  localparam logic [5:0] FLAG_BITS = 6'h01;
  localparam logic [5:0] LAG_BITS = 6'h04;
  localparam logic [3:0] NZ_MIN = 4'h3;
  localparam logic [3:0] ZC_PEAK_MIN = 4'h5;
  localparam logic [3:0] SB_COUNT = 4'h8;
  localparam logic [3:0] LAG_LAST = 4'he;
  localparam logic [3:0] ESC_CODE = 4'hf;
  // ratio above 4 means quantized above 5 times original
  localparam logic [14:0] ENV_RATIO_MUL = 15'h0005;
  // peak above 6x average of 8: 4*peak > 3*sum; 4x: 2*peak > sum
  localparam logic [17:0] PK_HI_L = 18'h0_0004;
  localparam logic [17:0] PK_HI_R = 18'h0_0003;
  localparam logic [17:0] PK_LO_L = 18'h0_0002;
  localparam logic [1:0] S2_HIGH = 2'h2;
  localparam logic [1:0] S2_LOW = 2'h1;

  typedef enum logic [1:0] {S_IDLE, S_SRCH1, S_SRCH2, S_DONE} zsf_state_e;

  typedef struct packed {
    logic both_layers;
    logic frame_class_a;
    logic [1:0] shb_mode;
    logic [5:0] unused1;
    logic [5:0] unused2;
    logic [7:0] zero_mask;
    logic [7:0][11:0] env_q;
    logic [7:0][11:0] env_o;
    logic [7:0][15:0] e_peak;
    logic [7:0][15:0] e_sum;
    logic [63:0][7:0] dec_spec;
    logic [63:0][7:0] orig_spec;
  } zsf_frame_in_s;

  typedef struct packed {
    logic flag_sent;
    logic flag_val;
    logic restrain_fill;
    logic lag1_sent;
    logic [3:0] lag1;
    logic signed [18:0] corr1;
    logic [17:0] energy1;
    logic [2:0] fill1_sb;
    logic lag2_sent;
    logic [3:0] lag2;
    logic signed [18:0] corr2;
    logic [17:0] energy2;
    logic [2:0] fill2_sb;
    logic [5:0] unused1_left;
    logic [5:0] unused2_left;
  } zsf_frame_out_s;
endpackage

// ===== verification/zsf_vq_source.sv
/*
  zsf_vq_source: model of the upstream quantizer stage that builds one
  frame of envelopes, energies and spectra and hands it to the block.
  assumes: mclk free running; frame_busy settles before the falling edge.
*/
`timescale 1ns/1ns
module zsf_vq_source (
  input wire logic mclk,
  input wire logic frame_busy,
  output logic frame_start,
  output zsf_pkg::zsf_frame_in_s frame_in
);
  zsf_pkg::zsf_frame_in_s nf;

  initial
  begin
    frame_start = 1'b0;
    frame_in = '0;
    nf = '0;
  end

  // kind 0 impulse base, 1 all negative target, 2 best correlation zero
  task automatic build(input logic both, input logic [1:0] mode,
    input logic [5:0] u1, input logic [5:0] u2, input logic [7:0] zm,
    input logic s1, input logic [1:0] s2, input logic ca,
    input logic [1:0] kind);
    nf = '0;
    nf.both_layers = both;
    nf.shb_mode = mode;
    nf.unused1 = u1;
    nf.unused2 = u2;
    nf.zero_mask = zm;
    nf.frame_class_a = ca;
    // coded sub-bands get a large error and peak so only zeros can count
    for (int j = 0; j < 8; j++)
    begin
      nf.env_o[j] = 12'h064;
      nf.env_q[j] = !zm[j] ? 12'h384 : s1 ? 12'h1f5 : 12'h1f4;
      nf.e_sum[j] = 16'h0320;
      nf.e_peak[j] = !zm[j] ? 16'h0320 : s2 == 2'h2 ? 16'h0259 :
        s2 == 2'h1 ? 16'h0191 : 16'h0190;
    end
    for (int k = 0; k < 24; k++)
      nf.dec_spec[k] = kind == 2'h1 ? 8'h01 : 8'h00;
    if (kind != 2'h1)
      nf.dec_spec[10] = 8'h03;
    for (int i = 24; i < 32; i++)
      nf.orig_spec[i] = kind == 2'h1 ? 8'hff : 8'h00;
    if (kind != 2'h1)
      nf.orig_spec[29] = kind == 2'h0 ? 8'h02 : 8'hfe;
    nf.orig_spec[34] = 8'h01;
  endtask

  // a frame is offered only when the block is idle; after the accept
  // edge the data are scrambled, as a real source would move on
  task automatic start(output logic ok);
    int n;
    n = 0;
    while (frame_busy !== 1'b0 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    ok = n < 100;
    @(posedge mclk);
    frame_start <= 1'b1;
    frame_in <= nf;
    @(posedge mclk);
    frame_start <= 1'b0;
    frame_in <= ~nf;
  endtask
endmodule

// ===== verification/zsf_zero_subband_fill_test.sv
/*
  zsf_zero_subband_fill_test: register and frame tests of the block.
  assumes: zsf_vq_source feeds frames; bus driven on rising edges.
*/
`timescale 1ns/1ns
module zsf_zero_subband_fill_test;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic frame_start;
  zsf_pkg::zsf_frame_in_s frame_in;
  logic frame_busy;
  logic frame_done;
  zsf_pkg::zsf_frame_out_s frame_out;
  int fails = 0;
  int num_checks = 0;
  logic [23:0] tbl_e = 24'h43_321f;
  int cnt_e = 0;
  logic f0_e = 1'b0;
  logic [31:0] rv;

  always #5 mclk = ~mclk;

  zsf_zero_subband_fill dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .frame_in(frame_in), .frame_busy(frame_busy),
    .frame_done(frame_done), .frame_out(frame_out));

  zsf_vq_source src (.mclk(mclk), .frame_busy(frame_busy),
    .frame_start(frame_start), .frame_in(frame_in));

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  // runs one frame, keeps the expected counter and flag, checks both
  task automatic frame(input logic both, input logic [1:0] mode,
    input logic [5:0] u1, input logic [5:0] u2, input logic [7:0] zm,
    input logic s1, input logic [1:0] s2, input logic ca,
    input logic [1:0] kind, input int cyc);
    logic ok;
    int n;
    int k;
    int nb;
    logic [1:0] s2e;
    s2e = (s2 == 2'h1 && $countones(zm) < 5) ? 2'h0 : s2;
    k = int'(s1 | ca) * 3 + int'(s2e);
    if (both && mode == 2'h0)
      cnt_e = cnt_e + $signed(tbl_e[4*k +: 4]);
    cnt_e = cnt_e < 0 ? 0 : cnt_e > 20 ? 20 : cnt_e;
    if (!both)
      f0_e = 1'b0;
    else if (u1 != 6'h00)
      f0_e = cnt_e != 0;
    src.build(both, mode, u1, u2, zm, s1, s2, ca, kind);
    src.start(ok);
    n = 0;
    nb = 0;
    // busy must stand in every cycle of the frame but the done cycle
    do
    begin
      @(negedge mclk);
      n++;
      nb += int'(frame_busy === 1'b1);
    end
    while (frame_done !== 1'b1 && n < 60);
    if (!ok || n >= 60)
    begin
      fails++;
      summarize();
    end
    chk("cycles", n, cyc);
    chk("sent", frame_out.flag_sent, both && u1 != 6'h00);
    chk("flag", frame_out.flag_val, both && u1 != 6'h00 && f0_e);
    chk("busy", nb, cyc - 1);
    chk("restrain", frame_out.restrain_fill,
      both && u1 != 6'h00 && f0_e);
    rd(4'h4, rv);
    chk("status", rv, {25'h0, 1'b0, f0_e, 5'(cnt_e)});
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values, read-only and unmapped places
    rd(4'h0, rv);
    chk("table", rv, 32'h0043_321f);
    wr(4'h4, 32'hffff_ffff);
    rd(4'h4, rv);
    chk("status", rv, 32'h0000_0000);
    rd(4'h8, rv);
    chk("lags", rv, 32'h0000_0000);
    rd(4'hc, rv);
    chk("unmapped", rv, 32'h0000_0000);
    // a write while the clock enable is low must leave the table alone
    ce <= 1'b0;
    wr(4'h0, 32'h0012_3456);
    ce <= 1'b1;
    rd(4'h0, rv);
    chk("table_ce", rv, 32'h0043_321f);
    $display("test reset done");
    // one search with exactly four bits left after the flag bit
    frame(1'b1, 2'h0, 6'h05, 6'h00, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h0, 17);
    chk("lag1_sent", frame_out.lag1_sent, 1'b1);
    chk("lag1", frame_out.lag1, 4'h5);
    chk("corr1", {13'h0, frame_out.corr1}, 32'h0000_0006);
    chk("energy1", frame_out.energy1, 18'h0_0009);
    chk("fill1_sb", frame_out.fill1_sb, 3'h3);
    chk("lag2_sent", frame_out.lag2_sent, 1'b0);
    chk("left1", frame_out.unused1_left, 6'h00);
    // two searches back to back in one frame
    frame(1'b1, 2'h0, 6'h05, 6'h06, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h0, 32);
    chk("lag2", frame_out.lag2, 4'h8);
    chk("corr2", {13'h0, frame_out.corr2}, 32'h0000_0003);
    chk("energy2", frame_out.energy2, 18'h0_0009);
    chk("fill2_sb", frame_out.fill2_sb, 3'h4);
    chk("left2", frame_out.unused2_left, 6'h02);
    rd(4'h8, rv);
    chk("lags", rv, 32'h0000_0085);
    // first layer short of bits: second search takes first target
    frame(1'b1, 2'h0, 6'h04, 6'h04, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h0, 17);
    chk("lag1_sent", frame_out.lag1_sent, 1'b0);
    chk("lag2", frame_out.lag2, 4'h5);
    chk("fill2_sb", frame_out.fill2_sb, 3'h3);
    chk("left1", frame_out.unused1_left, 6'h03);
    // negative and zero best correlation give the escape code
    frame(1'b1, 2'h0, 6'h05, 6'h00, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h1, 17);
    chk("lag1", frame_out.lag1, 4'hf);
    chk("corr1", {13'h0, frame_out.corr1}, 32'h0007_fff8);
    frame(1'b1, 2'h0, 6'h05, 6'h00, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h2, 17);
    chk("lag1", frame_out.lag1, 4'hf);
    // only two coded sub-bands: no filling
    frame(1'b1, 2'h0, 6'h05, 6'h06, 8'hfc, 1'b0, 2'h0, 1'b0, 2'h0, 2);
    chk("lag1_sent", frame_out.lag1_sent, 1'b0);
    chk("lag2_sent", frame_out.lag2_sent, 1'b0);
    chk("left1", frame_out.unused1_left, 6'h04);
    $display("test fill done");
    // deltas equal to the table index reveal both sub-flags
    wr(4'h0, 32'h0054_3210);
    tbl_e = 24'h54_3210;
    frame(1'b1, 2'h0, 6'h01, 6'h00, 8'hf8, 1'b1, 2'h0, 1'b0, 2'h0, 2);
    frame(1'b1, 2'h0, 6'h01, 6'h00, 8'hf8, 1'b0, 2'h2, 1'b0, 2'h0, 2);
    frame(1'b1, 2'h0, 6'h01, 6'h00, 8'hf8, 1'b0, 2'h1, 1'b0, 2'h0, 2);
    frame(1'b1, 2'h0, 6'h01, 6'h00, 8'hf0, 1'b0, 2'h1, 1'b0, 2'h0, 2);
    frame(1'b1, 2'h0, 6'h01, 6'h00, 8'hc0, 1'b0, 2'h0, 1'b1, 2'h0, 2);
    frame(1'b1, 2'h1, 6'h01, 6'h00, 8'hf8, 1'b1, 2'h2, 1'b0, 2'h0, 2);
    repeat (3)
      frame(1'b1, 2'h0, 6'h01, 6'h00, 8'hf8, 1'b1, 2'h2, 1'b0, 2'h0, 2);
    // flag set blocks the correlation fill
    frame(1'b1, 2'h0, 6'h05, 6'h06, 8'hf8, 1'b1, 2'h2, 1'b0, 2'h0, 2);
    chk("lag1_sent", frame_out.lag1_sent, 1'b0);
    chk("left1", frame_out.unused1_left, 6'h04);
    $display("test detect done");
    // counter falls; flag follows only when a spare bit exists
    wr(4'h0, 32'h0088_8888);
    tbl_e = 24'h88_8888;
    frame(1'b0, 2'h0, 6'h05, 6'h06, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h0, 2);
    frame(1'b1, 2'h0, 6'h00, 6'h00, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h0, 2);
    frame(1'b1, 2'h0, 6'h01, 6'h00, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h0, 2);
    frame(1'b1, 2'h0, 6'h00, 6'h00, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h0, 2);
    frame(1'b1, 2'h0, 6'h01, 6'h00, 8'hf8, 1'b0, 2'h0, 1'b0, 2'h0, 2);
    $display("test hold done");
    summarize();
  end
endmodule
